// >>> hw/guard_counter.sv
// Tick counter with restart, warning and expiry detection.
// Assumes tick_i is a one-cycle pulse per 1 kHz period.
`timescale 1ns/1ps
`default_nettype none
module guard_counter
	import guard_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Control
	input  wire logic              run_i,
	input  wire logic              tick_i,
	input  wire logic              restart_i,
	// Status
	output logic [TICK_W-1:0]      count_o,
	output logic                   warn_o,
	output logic                   expire_o
);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o <= '0;
		end else if (restart_i || !run_i) begin
			count_o <= '0;
		end else if (tick_i && count_o != TIMEOUT_TICKS) begin
			count_o <= count_o + 12'h001;
		end
	end

	assign warn_o   = run_i && tick_i && !restart_i && (count_o == WARN_TICKS - 12'h001);
	assign expire_o = run_i && tick_i && !restart_i && (count_o == TIMEOUT_TICKS - 12'h001);
endmodule
`default_nettype wire

// >>> hw/guard_edge.sv
// Rising-edge detector for a synchronous level such as the 1 kHz reference.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module guard_edge (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Level in, pulse out
	input  wire logic level_i,
	output logic      rise_o
);
	logic prev;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev <= 1'b0;
		end else begin
			prev <= level_i;
		end
	end

	assign rise_o = level_i & ~prev;
endmodule
`default_nettype wire

// >>> hw/guard_pkg.sv
// Constants, register map and timing for the watchdog block.
// Assumes a single 125 MHz clock and an AXI4-Lite register port.
// How it works
// - Watchdog stays disabled after power-up.
// - Count 1 kHz ticks, expire near two seconds.
// - Raise early-warning NMI at low-water point.
// - Any kick write restarts the count.
// - Freeze count during debug halt if enabled.
// - Hold count while 1 kHz reference stops.
// - Enable bit honoured only after enable code.
// - Disable bit honoured only after disable code.
// - Unarmed enable/disable writes are ignored.
// - Writes accepted only in privileged mode.
// - Registers live in always-on domain.
// - Expiry restarts system, records cause bit 3.
package guard_pkg;
	localparam logic [31:0] GUARD_CONFIG_ADDR = 32'h4000_6000;
	localparam logic [31:0] GUARD_ARMING_ADDR = 32'h4000_6004;
	localparam logic [31:0] GUARD_KICK_ADDR   = 32'h4000_6008;
	localparam logic [31:0] GUARD_IRQ_STAT_ADDR = 32'h4000_6040;
	localparam logic [31:0] GUARD_IRQ_MASK_ADDR = 32'h4000_6044;
	localparam logic [31:0] GUARD_CAUSE_ADDR    = 32'h4000_6048;
	localparam logic [31:0] GUARD_CTL_ADDR      = 32'h4000_604C;
	localparam logic [31:0] GUARD_CONFIG_RESET  = 32'h0000_0002;
	localparam int          EN_BIT    = 0;
	localparam int          DIS_BIT   = 1;
	localparam int          CAUSE_BIT = 3;
	localparam int          PAUSE_BIT = 0;
	localparam int          IRQ_WARN  = 0;
	localparam int          IRQ_EXPIRE = 1;
	localparam logic [15:0] ENABLE_CODE  = 16'hEABE;
	localparam logic [15:0] DISABLE_CODE = 16'hDEAD;
	localparam int          TICK_W       = 12;
	localparam logic [11:0] TIMEOUT_TICKS = 12'h0800;
	localparam logic [11:0] WARN_TICKS    = 12'h0700;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [2:0]  PROT_PRIV   = 3'h1;
	localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
	typedef enum logic [1:0] {
		ARM_NONE    = 2'b00,
		ARM_ENABLE  = 2'b01,
		ARM_DISABLE = 2'b11
	} arm_t;
endpackage

// >>> hw/watchdog_timer.sv
// Watchdog timer top: AXI4-Lite slave, two-step enable logic and reset cause.
// Assumes all inputs synchronous to REF_CLK_I and reset from the always-on domain.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
	import guard_pkg::*;
(
	// Clock and reset
	input  wire logic        REF_CLK_I,
	input  wire logic        RESET_N_I,
	// Write address channel
	input  wire logic [31:0] AWADDR_I,
	input  wire logic [2:0]  AWPROT_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	// Write data channel
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	// Write response channel
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// Read address channel
	input  wire logic [31:0] ARADDR_I,
	input  wire logic [2:0]  ARPROT_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	// Read data channel
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// Timing reference and debug
	input  wire logic        CALIBRATED_1KHZ_REF_I,
	input  wire logic        DEBUG_HALT_I,
	// Outputs
	output logic             EARLY_NMI_O,
	output logic             SYSTEM_RESTART_O,
	output logic             IRQ_O
);
	// ----------------------------------------------------------------
	// Write channel capture
	// ----------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr;
	logic [2:0]  aw_prot;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        wr_priv;

	assign AWREADY_O = !aw_held && !BVALID_O;
	assign WREADY_O  = !w_held && !BVALID_O;
	assign wr_go     = aw_held && w_held && !BVALID_O;
	// Unprivileged writes complete with an error and change nothing.
	assign wr_priv   = (aw_prot & PROT_PRIV) != 3'h0;

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			aw_held <= 1'b0;
			aw_addr <= ZERO_WORD;
			aw_prot <= 3'h0;
		end else if (AWVALID_I && AWREADY_O) begin
			aw_held <= 1'b1;
			aw_addr <= AWADDR_I;
			aw_prot <= AWPROT_I;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			w_held <= 1'b0;
			w_data <= ZERO_WORD;
			w_strb <= 4'h0;
		end else if (WVALID_I && WREADY_O) begin
			w_held <= 1'b1;
			w_data <= WDATA_I;
			w_strb <= WSTRB_I;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic wr_ok;
	logic wr_mapped;
	logic wr_config;
	logic wr_arming;
	logic wr_kick;
	logic wr_stat;
	logic wr_mask;
	logic wr_ctl;
	logic lo_bytes;

	assign wr_mapped = aw_addr == GUARD_CONFIG_ADDR || aw_addr == GUARD_ARMING_ADDR
		|| aw_addr == GUARD_KICK_ADDR || aw_addr == GUARD_IRQ_STAT_ADDR
		|| aw_addr == GUARD_IRQ_MASK_ADDR || aw_addr == GUARD_CAUSE_ADDR
		|| aw_addr == GUARD_CTL_ADDR;
	assign wr_ok     = wr_go && wr_priv && wr_mapped;
	assign lo_bytes  = w_strb[1:0] == 2'b11;
	assign wr_config = wr_ok && aw_addr == GUARD_CONFIG_ADDR && w_strb[0];
	assign wr_arming = wr_ok && aw_addr == GUARD_ARMING_ADDR && lo_bytes;
	// A kick counts whatever the data or byte lanes.
	assign wr_kick   = wr_ok && aw_addr == GUARD_KICK_ADDR;
	assign wr_stat   = wr_ok && aw_addr == GUARD_IRQ_STAT_ADDR && w_strb[0];
	assign wr_mask   = wr_ok && aw_addr == GUARD_IRQ_MASK_ADDR && w_strb[0];
	assign wr_ctl    = wr_ok && aw_addr == GUARD_CTL_ADDR && w_strb[0];

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			BVALID_O <= 1'b0;
			BRESP_O  <= RESP_OKAY;
		end else if (wr_go) begin
			BVALID_O <= 1'b1;
			BRESP_O  <= (wr_priv && wr_mapped) ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY_I) begin
			BVALID_O <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Arming and enable state
	// ----------------------------------------------------------------
	arm_t arm;
	logic enabled;
	logic debug_halt_freeze;
	logic take_en;
	logic take_dis;

	// State here sits on the always-on reset, so it survives core power-down.
	assign take_en  = wr_config && w_data[EN_BIT] && arm == ARM_ENABLE;
	assign take_dis = wr_config && w_data[DIS_BIT] && arm == ARM_DISABLE;

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			arm <= ARM_NONE;
		end else if (take_en || take_dis) begin
			arm <= ARM_NONE;
		end else if (wr_arming) begin
			case (w_data[15:0])
				ENABLE_CODE:  arm <= ARM_ENABLE;
				DISABLE_CODE: arm <= ARM_DISABLE;
				default:      arm <= ARM_NONE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			enabled <= 1'b0;
		end else if (take_dis) begin
			enabled <= 1'b0;
		end else if (take_en) begin
			enabled <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			debug_halt_freeze <= 1'b0;
		end else if (wr_ctl) begin
			debug_halt_freeze <= w_data[PAUSE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	logic              ref_rise;
	logic              tick;
	logic              warn;
	logic              expire;
	logic [TICK_W-1:0] count;

	guard_edge u_edge (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RESET_N_I),
		.level_i (CALIBRATED_1KHZ_REF_I),
		.rise_o  (ref_rise)
	);

	// No reference edges means no ticks, so a stopped oscillator holds the count.
	assign tick = ref_rise && !(debug_halt_freeze && DEBUG_HALT_I);

	guard_counter u_count (
		.clk_i     (REF_CLK_I),
		.rst_n_i   (RESET_N_I),
		.run_i     (enabled),
		.tick_i    (tick),
		.restart_i (wr_kick),
		.count_o   (count),
		.warn_o    (warn),
		.expire_o  (expire)
	);

	// ----------------------------------------------------------------
	// Events, cause and interrupt
	// ----------------------------------------------------------------
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic       cause;
	logic [1:0] events;

	assign events = {expire, warn};

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			EARLY_NMI_O      <= 1'b0;
			SYSTEM_RESTART_O <= 1'b0;
		end else begin
			EARLY_NMI_O      <= warn;
			SYSTEM_RESTART_O <= expire;
		end
	end

	// Set wins over a write-one clear in the same cycle.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			irq_stat <= 2'b00;
		end else begin
			irq_stat <= (irq_stat & ~(wr_stat ? w_data[1:0] : 2'b00)) | events;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			irq_mask <= 2'b00;
		end else if (wr_mask) begin
			irq_mask <= w_data[1:0];
		end
	end

	// The cause bit survives the restart pulse; software clears it by writing one.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			cause <= 1'b0;
		end else if (expire) begin
			cause <= 1'b1;
		end else if (wr_ok && aw_addr == GUARD_CAUSE_ADDR && w_data[CAUSE_BIT]) begin
			cause <= 1'b0;
		end
	end

	assign IRQ_O = (irq_stat & irq_mask) != 2'b00;

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic        rd_hit;

	assign ARREADY_O = !RVALID_O;

	always_comb begin
		rd_word = ZERO_WORD;
		rd_hit  = 1'b1;
		case (ARADDR_I)
			GUARD_CONFIG_ADDR:   rd_word = {30'h0, !enabled, enabled};
			GUARD_ARMING_ADDR:   rd_word = ZERO_WORD;
			GUARD_KICK_ADDR:     rd_word = ZERO_WORD;
			GUARD_IRQ_STAT_ADDR: rd_word = {30'h0, irq_stat};
			GUARD_IRQ_MASK_ADDR: rd_word = {30'h0, irq_mask};
			GUARD_CAUSE_ADDR:    rd_word = {28'h0, cause, 3'h0};
			GUARD_CTL_ADDR:      rd_word = {20'h0, count[TICK_W-1:1], debug_halt_freeze};
			default:             rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RVALID_O <= 1'b0;
			RDATA_O  <= ZERO_WORD;
			RRESP_O  <= RESP_OKAY;
		end else if (ARVALID_I && ARREADY_O) begin
			RVALID_O <= 1'b1;
			RDATA_O  <= rd_word;
			RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/watchdog_timer_sva.sv
// Port checker for the watchdog block.
// Assumes it is bound to watchdog_timer, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_sva
	import guard_pkg::*;
(
	input wire logic        REF_CLK_I,
	input wire logic        RESET_N_I,
	input wire logic [2:0]  AWPROT_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	input wire logic        EARLY_NMI_O,
	input wire logic        SYSTEM_RESTART_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// ----------------------------------------
	// Bus and event properties
	// ----------------------------------------
	// Both channels are taken at one edge, the slave decodes in the next cycle and
	// raises the response at the edge after that, so it is seen two edges on.
	a_wr_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
		else $error("write answer late");
	a_unpriv_err: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
		&& !AWPROT_I[0] |-> ##2 BRESP_O == RESP_SLVERR)
		else $error("unprivileged write not refused");
	a_b_stands: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped");
	a_r_stands: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read data dropped");
	a_rd_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read answer late");
	a_aw_blocked: assert property (BVALID_O |-> !AWREADY_O)
		else $error("address taken while response pending");
	a_nmi_pulse: assert property (EARLY_NMI_O |=> !EARLY_NMI_O [*8])
		else $error("warning not a single pulse");
	a_exp_pulse: assert property (SYSTEM_RESTART_O |=> !SYSTEM_RESTART_O [*8])
		else $error("restart not a single pulse");
	a_warn_apart: assert property (SYSTEM_RESTART_O |-> !EARLY_NMI_O)
		else $error("warning and expiry together");
	cover property (EARLY_NMI_O);
	cover property (SYSTEM_RESTART_O);
	cover property (BVALID_O && BRESP_O == RESP_SLVERR);
endmodule
`default_nettype wire

// >>> tb/watchdog_timer_test.sv
// Self-checking bench for the watchdog block.
// Assumes guard_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_test;
	import guard_pkg::*;
	logic        REF_CLK_I = 0, RESET_N_I = 0, CALIBRATED_1KHZ_REF_I = 0, DEBUG_HALT_I = 0;
	logic [31:0] AWADDR_I = '0, WDATA_I = '0, ARADDR_I = '0, RDATA_O, rd;
	logic [2:0]  AWPROT_I = '0, ARPROT_I = '0;
	logic [3:0]  WSTRB_I = '0;
	logic        AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
	logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	logic        EARLY_NMI_O, SYSTEM_RESTART_O, IRQ_O;
	logic [1:0]  BRESP_O, RRESP_O, resp;
	logic [31:0] seed = 32'h0000_4b1e;
	int          num_errors = 0, total_checks = 0, cyc = 0, nmis = 0, exps = 0;

	watchdog_timer dut_u (.REF_CLK_I, .RESET_N_I, .AWADDR_I, .AWPROT_I, .AWVALID_I,
		.AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O,
		.BREADY_I, .ARADDR_I, .ARPROT_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
		.RVALID_O, .RREADY_I, .CALIBRATED_1KHZ_REF_I, .DEBUG_HALT_I, .EARLY_NMI_O,
		.SYSTEM_RESTART_O, .IRQ_O);

	always #4 REF_CLK_I = ~REF_CLK_I;

	// Pulses are counted on the falling edge, where they are settled.
	always @(negedge REF_CLK_I) begin
		cyc++;
		if (EARLY_NMI_O === 1'b1) nmis++;
		if (SYSTEM_RESTART_O === 1'b1) exps++;
		if (cyc == 60000) begin
			num_errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [31:0] cfg_exp(input logic en);
		return {30'h0000_0000, !en, en};
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Ready is looked at on the falling edge, so the taking edge is known in advance.
	task automatic wr(input logic [31:0] a, d, input logic [2:0] p);
		logic ga, gw, gb;
		@(posedge REF_CLK_I);
		AWADDR_I  <= a;
		AWPROT_I  <= p;
		WDATA_I   <= d;
		WSTRB_I   <= 4'hf;
		AWVALID_I <= 1'b1;
		WVALID_I  <= 1'b1;
		BREADY_I  <= 1'b1;
		gb = 1'b0;
		while (!gb) begin
			@(negedge REF_CLK_I);
			ga = AWVALID_I && AWREADY_O;
			gw = WVALID_I && WREADY_O;
			gb = BVALID_O;
			resp = BRESP_O;
			@(posedge REF_CLK_I);
			if (ga) AWVALID_I <= 1'b0;
			if (gw) WVALID_I <= 1'b0;
			if (gb) BREADY_I <= 1'b0;
		end
	endtask
	task automatic rd_reg(input logic [31:0] a);
		logic ga, go;
		seed = nxt(seed);
		@(posedge REF_CLK_I);
		ARADDR_I  <= a;
		ARPROT_I  <= seed[2:0];
		ARVALID_I <= 1'b1;
		RREADY_I  <= 1'b1;
		go = 1'b0;
		while (!go) begin
			@(negedge REF_CLK_I);
			ga = ARVALID_I && ARREADY_O;
			go = RVALID_O;
			rd = RDATA_O;
			resp = RRESP_O;
			@(posedge REF_CLK_I);
			if (ga) ARVALID_I <= 1'b0;
			if (go) RREADY_I <= 1'b0;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge REF_CLK_I);
			CALIBRATED_1KHZ_REF_I <= 1'b1;
			@(posedge REF_CLK_I);
			@(posedge REF_CLK_I);
			CALIBRATED_1KHZ_REF_I <= 1'b0;
			@(posedge REF_CLK_I);
		end
		repeat (4) @(posedge REF_CLK_I);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge REF_CLK_I);
		RESET_N_I <= 1'b1;
		rd_reg(GUARD_CONFIG_ADDR);
		chk("config reset", rd, cfg_exp(1'b0));
		rd_reg(32'h4000_6100);
		chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
		for (int i = 0; i < 4; i++) begin
			seed = nxt(seed);
			wr(GUARD_ARMING_ADDR, {20'h0_0000, seed[11:0]}, PROT_PRIV);
			wr(GUARD_CONFIG_ADDR, 32'h0000_0001, PROT_PRIV);
			rd_reg(GUARD_CONFIG_ADDR);
			chk("unarmed enable", rd, cfg_exp(1'b0));
		end
		wr(GUARD_ARMING_ADDR, {16'h0000, DISABLE_CODE}, PROT_PRIV);
		wr(GUARD_CONFIG_ADDR, 32'h0000_0001, PROT_PRIV);
		wr(GUARD_ARMING_ADDR, {16'h0000, ENABLE_CODE}, 3'h0);
		chk("unpriv resp", 32'(resp), 32'(RESP_SLVERR));
		wr(GUARD_CONFIG_ADDR, 32'h0000_0001, PROT_PRIV);
		rd_reg(GUARD_CONFIG_ADDR);
		chk("wrong code", rd, cfg_exp(1'b0));
		wr(GUARD_ARMING_ADDR, {16'h0000, ENABLE_CODE}, PROT_PRIV);
		wr(GUARD_CONFIG_ADDR, 32'h0000_0001, PROT_PRIV);
		wr(GUARD_CONFIG_ADDR, 32'h0000_0002, PROT_PRIV);
		rd_reg(GUARD_CONFIG_ADDR);
		chk("armed enable", rd, cfg_exp(1'b1));
		wr(GUARD_ARMING_ADDR, {16'h0000, ENABLE_CODE}, PROT_PRIV);
		wr(GUARD_CONFIG_ADDR, 32'h0000_0002, PROT_PRIV);
		rd_reg(GUARD_CONFIG_ADDR);
		chk("disable wrong code", rd, cfg_exp(1'b1));
		$display("arming test done");
		wr(GUARD_IRQ_MASK_ADDR, 32'h0000_0003, PROT_PRIV);
		tick(1791);
		chk("no early warning", 32'(nmis), 32'h0000_0000);
		tick(1);
		chk("warning", 32'(nmis), 32'h0000_0001);
		chk("irq set", 32'(IRQ_O), 32'h0000_0001);
		wr(GUARD_IRQ_MASK_ADDR, 32'h0000_0000, PROT_PRIV);
		@(negedge REF_CLK_I);
		chk("irq masked", 32'(IRQ_O), 32'h0000_0000);
		wr(GUARD_IRQ_MASK_ADDR, 32'h0000_0003, PROT_PRIV);
		seed = nxt(seed);
		wr(GUARD_KICK_ADDR, seed, PROT_PRIV);
		tick(1791);
		chk("kick restarts", 32'(nmis), 32'h0000_0001);
		wr(GUARD_CTL_ADDR, 32'h0000_0001, PROT_PRIV);
		@(posedge REF_CLK_I);
		DEBUG_HALT_I <= 1'b1;
		tick(8);
		rd_reg(GUARD_CTL_ADDR);
		chk("halt freeze", 32'(rd[11:1]), 32'(1791 >> 1));
		// The halt is lifted first, so only the silent reference can hold the count.
		DEBUG_HALT_I <= 1'b0;
		repeat (300) @(posedge REF_CLK_I);
		rd_reg(GUARD_CTL_ADDR);
		chk("ref stopped", 32'(rd[11:1]), 32'(1791 >> 1));
		tick(1);
		chk("resume", 32'(nmis), 32'h0000_0002);
		tick(255);
		chk("no early expiry", 32'(exps), 32'h0000_0000);
		tick(1);
		chk("expiry", 32'(exps), 32'h0000_0001);
		rd_reg(GUARD_CAUSE_ADDR);
		chk("cause bit", 32'(rd[CAUSE_BIT]), 32'h0000_0001);
		wr(GUARD_CAUSE_ADDR, 32'h0000_0008, PROT_PRIV);
		rd_reg(GUARD_CAUSE_ADDR);
		chk("cause cleared", rd, ZERO_WORD);
		tick(5);
		chk("single expiry", 32'(exps), 32'h0000_0001);
		wr(GUARD_IRQ_STAT_ADDR, 32'h0000_0003, PROT_PRIV);
		@(negedge REF_CLK_I);
		chk("irq cleared", 32'(IRQ_O), 32'h0000_0000);
		wr(GUARD_ARMING_ADDR, {16'h0000, DISABLE_CODE}, PROT_PRIV);
		wr(GUARD_CONFIG_ADDR, 32'h0000_0002, PROT_PRIV);
		rd_reg(GUARD_CONFIG_ADDR);
		chk("armed disable", rd, cfg_exp(1'b0));
		$display("counting test done");
		report_and_stop();
	end
endmodule

bind watchdog_timer watchdog_timer_sva chk_u (.REF_CLK_I, .RESET_N_I, .AWPROT_I,
	.AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I,
	.ARVALID_I, .ARREADY_O, .RDATA_O, .RVALID_O, .RREADY_I, .EARLY_NMI_O,
	.SYSTEM_RESTART_O);
`default_nettype wire
